// >>> rtl/encnode_pkg.sv
// constants, types and frame carrier shared by the encoder node design
package encnode_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int MS_PER_S = 1_000;
    localparam int MEAS_LIMIT_US = 100;
    // longest time: rounds down, 4000 cycles
    localparam int MEAS_CYCLES = CLK_HZ / US_PER_S * MEAS_LIMIT_US;
    // one millisecond, default of the top-level divider parameter
    localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;

    // ------------------------------------------------------------
    // bus identifiers and state command codes
    // ------------------------------------------------------------
    localparam logic [10:0] ID_NMT = 11'h000;
    localparam logic [10:0] ID_SYNC = 11'h080;
    localparam logic [10:0] ID_PDO_BASE = 11'h180;
    localparam logic [10:0] ID_PDO_STEP = 11'h100;
    localparam logic [10:0] ID_BOOT = 11'h700;
    localparam logic [7:0] NODE_ALL = 8'h00;
    localparam logic [7:0] CMD_START = 8'h01;
    localparam logic [7:0] CMD_STOP = 8'h02;
    localparam logic [7:0] CMD_PREOP = 8'h80;
    localparam logic [7:0] CMD_RST_NODE = 8'h81;
    localparam logic [7:0] CMD_RST_COMM = 8'h82;
    localparam logic [3:0] DLC_NMT = 4'h2;
    localparam logic [3:0] DLC_BOOT = 4'h1;
    localparam logic [3:0] DLC_PDO = 4'h4;

    // ------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CYCLE = 8'h04;
    localparam logic [7:0] ADDR_SYNC = 8'h08;
    localparam logic [7:0] ADDR_PRESET = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_POS_BASE = 8'h14;
    localparam logic [7:0] ADDR_STEP = 8'h04;
    localparam int CTRL_NODE_LSB = 0;
    localparam int CTRL_MODE_LSB = 8;
    localparam int STAT_STALE_LSB = 8;
    localparam logic [6:0] NODE_RST = 7'h01;
    localparam logic [15:0] CYCLE_RST = 16'h0063; // period minus one ms
    localparam logic [7:0] SYNC_TYPE_RST = 8'h01;
    localparam logic [31:0] PRESET_RST = 32'h00000000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_POLL, MODE_CYCLIC, MODE_SYNC} tx_mode_t;
    typedef enum logic [1:0] {ST_BOOT, ST_PREOP, ST_OPER, ST_STOP} node_state_t;

    typedef struct packed {
        logic [10:0] id;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data; // byte 0 in bits 7:0
    } can_frame_t;

endpackage

// >>> rtl/pos_channel.sv
// one encoder channel: synchronised position capture, preset and age watch
`timescale 1ns/1ps
module pos_channel
    import encnode_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic toggle_in,
    input wire logic [W-1:0] raw_in,
    input wire logic [W-1:0] preset,
    output logic [W-1:0] pos,
    output logic stale
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic tg_s1;
        logic tg_s2;
        logic tg_s3;
        logic [W-1:0] d_s1;
        logic [W-1:0] d_s2;
        logic [W-1:0] pos;
        logic [12:0] age;
        logic stale;
    } ch_t;

    localparam logic [12:0] AGE_MAX = 13'(MEAS_CYCLES);

    ch_t c_r;
    ch_t c_nxt;

    // sample pins, catch a new measurement on each toggle edge
    always_comb begin
        c_nxt = c_r;
        c_nxt.tg_s1 = toggle_in;
        c_nxt.tg_s2 = c_r.tg_s1;
        c_nxt.tg_s3 = c_r.tg_s2;
        c_nxt.d_s1 = raw_in;
        c_nxt.d_s2 = c_r.d_s1;
        if (c_r.tg_s2 != c_r.tg_s3) begin
            c_nxt.pos = c_r.d_s2 + preset;
            c_nxt.age = '0;
            c_nxt.stale = 1'b0;
        end else if (c_r.age >= AGE_MAX) begin
            c_nxt.stale = 1'b1;
        end else begin
            c_nxt.age = c_r.age + 13'h0001;
        end
    end

    // register the channel state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign pos = c_r.pos;
    assign stale = c_r.stale;

endmodule

// >>> rtl/encnode_top.sv
// state machine and position transmission of the encoder network node
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module encnode_top
    import encnode_pkg::*;
#(
    parameter int NCH = 2,
    parameter int POS_W = 32,
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire can_frame_t rx_frame,
    output logic tx_valid,
    output can_frame_t tx_frame,
    input wire logic tx_ready,
    input wire logic [NCH-1:0] pos_toggle,
    input wire logic [NCH-1:0][POS_W-1:0] pos_raw,
    output node_state_t node_state,
    output logic sdo_enable,
    output logic [NCH-1:0] pos_stale
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int DIV_W = $clog2(MS_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

    typedef struct packed {
        node_state_t st;
        logic [6:0] node;
        tx_mode_t mode;
        logic [15:0] cyc_per;
        logic [7:0] sync_type;
        logic [POS_W-1:0] preset;
        logic [DIV_W-1:0] div;
        logic [15:0] ms_cnt;
        logic [7:0] sync_cnt;
        logic [NCH-1:0] pend;
        logic boot_pend;
        logic tx_valid;
        can_frame_t tx;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sdo_en;
    } node_t;

    node_t s_r;
    node_t s_nxt;

    logic [NCH-1:0][POS_W-1:0] ch_pos;
    logic [NCH-1:0] ch_stale;

    // ------------------------------------------------------------
    // encoder channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        pos_channel #(
            .W(POS_W)
        ) u_ch (
            .clk(clk),
            .rstn(rstn),
            .toggle_in(pos_toggle[g]),
            .raw_in(pos_raw[g]),
            .preset(s_r.preset),
            .pos(ch_pos[g]),
            .stale(ch_stale[g])
        );
    end

    // identifier of a channel's position frame
    function automatic logic [10:0] pdo_id(input int ch,
                                           input logic [6:0] node);
        logic [10:0] step;
        step = 11'(ch) * ID_PDO_STEP;
        return ID_PDO_BASE + step + {4'h0, node};
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] cmd;
        logic [7:0] target;
        logic hit;
        logic tick;
        logic rst_comm;
        logic rst_node;
        logic picked;
        logic [7:0] skip;
        logic [NCH-1:0] req;
        s_nxt = s_r;
        cmd = rx_frame.data[7:0];
        target = rx_frame.data[15:8];
        hit = 1'b0;
        tick = 1'b0;
        rst_comm = 1'b0;
        rst_node = 1'b0;
        picked = 1'b0;
        req = '0;
        skip = (s_r.sync_type == 8'h00) ? SYNC_TYPE_RST : s_r.sync_type;

        // apb slave: one wait state, answer registered
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = '0;
            unique case (paddr)
                ADDR_CTRL: begin
                    s_nxt.prdata[CTRL_NODE_LSB +: 7] = s_r.node;
                    s_nxt.prdata[CTRL_MODE_LSB +: 2] = s_r.mode;
                    if (pwrite) begin
                        s_nxt.node = pwdata[CTRL_NODE_LSB +: 7];
                        s_nxt.mode = tx_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
                    end
                end
                ADDR_CYCLE: begin
                    s_nxt.prdata[15:0] = s_r.cyc_per;
                    if (pwrite) begin
                        s_nxt.cyc_per = pwdata[15:0];
                    end
                end
                ADDR_SYNC: begin
                    s_nxt.prdata[7:0] = s_r.sync_type;
                    if (pwrite) begin
                        s_nxt.sync_type = pwdata[7:0];
                        s_nxt.sync_cnt = '0;
                    end
                end
                ADDR_PRESET: begin
                    s_nxt.prdata[POS_W-1:0] = s_r.preset;
                    if (pwrite) begin
                        s_nxt.preset = pwdata[POS_W-1:0];
                    end
                end
                ADDR_STATUS: begin
                    s_nxt.prdata[1:0] = s_r.st;
                    s_nxt.prdata[STAT_STALE_LSB +: NCH] = ch_stale;
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                    for (int c = 0; c < NCH; c++) begin
                        if (paddr == ADDR_POS_BASE + 8'(c) * ADDR_STEP) begin
                            s_nxt.prdata[POS_W-1:0] = ch_pos[c];
                            s_nxt.pslverr = 1'b0;
                        end
                    end
                    if (pwrite) begin
                        s_nxt.pslverr = 1'b1;
                    end
                end
            endcase
        end

        // millisecond enable
        if (s_r.div == DIV_LAST) begin
            s_nxt.div = '0;
            tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + DIV_W'(1);
        end

        // received frames, each handled in one cycle
        if (rx_valid) begin
            if (rx_frame.id == ID_NMT && !rx_frame.rtr &&
                rx_frame.dlc >= DLC_NMT &&
                (target == NODE_ALL || target == {1'b0, s_r.node})) begin
                hit = 1'b1;
            end
            if (hit && s_r.st != ST_BOOT) begin
                unique case (cmd)
                    CMD_PREOP: s_nxt.st = ST_PREOP;
                    CMD_START: s_nxt.st = ST_OPER;
                    CMD_STOP: s_nxt.st = ST_STOP;
                    CMD_RST_COMM: rst_comm = 1'b1;
                    CMD_RST_NODE: rst_node = 1'b1;
                    default: ;
                endcase
            end else if (s_r.st == ST_OPER) begin
                if (rx_frame.id == ID_SYNC && !rx_frame.rtr &&
                    s_r.mode == MODE_SYNC) begin
                    if (s_r.sync_cnt + 8'h01 >= skip) begin
                        s_nxt.sync_cnt = '0;
                        req = '1;
                    end else begin
                        s_nxt.sync_cnt = s_r.sync_cnt + 8'h01;
                    end
                end
                for (int c = 0; c < NCH; c++) begin
                    if (rx_frame.rtr && s_r.mode == MODE_POLL &&
                        rx_frame.id == pdo_id(c, s_r.node)) begin
                        req[c] = 1'b1;
                    end
                end
            end
        end

        // cyclic period in whole milliseconds
        if (s_r.st == ST_OPER && s_r.mode == MODE_CYCLIC) begin
            if (tick) begin
                if (s_r.ms_cnt >= s_r.cyc_per) begin
                    s_nxt.ms_cnt = '0;
                    req = '1;
                end else begin
                    s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
                end
            end
        end else begin
            s_nxt.ms_cnt = '0;
        end

        // transmit: bootup first, then channels in index order
        if (s_r.tx_valid && tx_ready) begin
            s_nxt.tx_valid = 1'b0;
            if (s_r.st == ST_BOOT && !s_r.boot_pend) begin
                s_nxt.st = ST_PREOP;
            end
        end
        if (!s_r.tx_valid) begin
            if (s_r.boot_pend) begin
                s_nxt.boot_pend = 1'b0;
                s_nxt.tx_valid = 1'b1;
                s_nxt.tx.id = ID_BOOT + {4'h0, s_r.node};
                s_nxt.tx.rtr = 1'b0;
                s_nxt.tx.dlc = DLC_BOOT;
                s_nxt.tx.data = '0;
            end else if (s_r.st == ST_OPER) begin
                for (int c = 0; c < NCH; c++) begin
                    if (s_r.pend[c] && !picked) begin
                        picked = 1'b1;
                        s_nxt.pend[c] = 1'b0;
                        s_nxt.tx_valid = 1'b1;
                        s_nxt.tx.id = pdo_id(c, s_r.node);
                        s_nxt.tx.rtr = 1'b0;
                        s_nxt.tx.dlc = DLC_PDO;
                        s_nxt.tx.data = 64'(ch_pos[c]);
                    end
                end
            end
        end

        // a new request beats the clear of the channel just sent
        s_nxt.pend = s_nxt.pend | req;

        // outside operational no process data is queued
        if (s_nxt.st != ST_OPER) begin
            s_nxt.pend = '0;
        end
        s_nxt.sdo_en = (s_nxt.st != ST_STOP);

        // communication or node reset: restart with bootup
        if (rst_comm || rst_node) begin
            s_nxt.st = ST_BOOT;
            s_nxt.boot_pend = 1'b1;
            s_nxt.pend = '0;
            s_nxt.mode = MODE_SYNC;
            s_nxt.cyc_per = CYCLE_RST;
            s_nxt.sync_type = SYNC_TYPE_RST;
            s_nxt.sync_cnt = '0;
            s_nxt.ms_cnt = '0;
            s_nxt.sdo_en = 1'b1;
            if (rst_node) begin
                s_nxt.preset = PRESET_RST;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.st <= ST_BOOT;
            s_r.node <= NODE_RST;
            s_r.mode <= MODE_SYNC;
            s_r.cyc_per <= CYCLE_RST;
            s_r.sync_type <= SYNC_TYPE_RST;
            s_r.preset <= PRESET_RST;
            s_r.boot_pend <= 1'b1;
            s_r.sdo_en <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign tx_valid = s_r.tx_valid;
    assign tx_frame = s_r.tx;
    assign node_state = s_r.st;
    assign sdo_enable = s_r.sdo_en;
    assign pos_stale = ch_stale;

endmodule

// >>> sim/encnode_top_properties.sv
// concurrent checks on the encoder node ports
`timescale 1ns/1ps
module encnode_top_properties
    import encnode_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire can_frame_t rx_frame,
    input wire logic tx_valid,
    input wire can_frame_t tx_frame,
    input wire logic tx_ready,
    input wire node_state_t node_state,
    input wire logic sdo_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // broadcast state command and its effect
    // ------------------------------------------------------------
    sequence s_nmt_all(logic [7:0] code);
        rx_valid && rx_frame.id == ID_NMT && !rx_frame.rtr &&
        rx_frame.dlc >= DLC_NMT && rx_frame.data[7:0] == code &&
        rx_frame.data[15:8] == NODE_ALL && node_state != ST_BOOT;
    endsequence
    sequence s_stall;
        tx_valid && !tx_ready;
    endsequence
    property p_goes(logic [7:0] code, node_state_t st);
        s_nmt_all(code) |=> node_state == st;
    endproperty

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_goto_preop: assert property (p_goes(CMD_PREOP, ST_PREOP))
        else $error("preop command missed");
    a_goto_oper: assert property (p_goes(CMD_START, ST_OPER))
        else $error("start command missed");
    a_goto_stop: assert property (p_goes(CMD_STOP, ST_STOP))
        else $error("stop command missed");
    a_boot_send: assert property ($past(rstn) && !tx_valid
        && node_state == ST_BOOT |=> tx_valid)
        else $error("no bootup frame offered");
    a_boot_frame: assert property (node_state == ST_BOOT && tx_valid
        |-> tx_frame.id[10:7] == 4'hE && tx_frame.dlc == DLC_BOOT)
        else $error("bootup frame malformed");
    a_quiet_idle: assert property (node_state != ST_OPER && !tx_valid
        |=> !tx_valid || tx_frame.id[10:7] == 4'hE)
        else $error("process data loaded outside operational");
    a_stop_sdo: assert property ($stable(node_state)
        |-> sdo_enable == (node_state != ST_STOP))
        else $error("service data enable wrong for state");
    a_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_frame))
        else $error("frame changed while stalled");
    a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("no idle cycle after accepted frame");
    a_apb_wait: assert property (psel && penable && !pready
        |=> pready ##1 !pready) else $error("register answer timing wrong");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
endmodule

bind encnode_top encnode_top_properties chk (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .tx_ready(tx_ready), .node_state(node_state),
    .sdo_enable(sdo_enable));

// >>> sim/can_master_model.sv
// far-side bus controller model: injects frames and logs node output
`timescale 1ns/1ps
module can_master_model
    import encnode_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic tx_valid,
    input wire can_frame_t tx_frame,
    output logic tx_ready,
    output logic rx_valid,
    output can_frame_t rx_frame
);
    can_frame_t got[$];
    int stamp[$];
    int cyc = 0;
    logic [3:0] pat = 4'h1;

    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
    end

    // ready is prompt, or follows a shifting pattern when slow
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_ready <= 1'b0;
        end else begin
            pat <= {pat[2:0], pat[3] ^ pat[2]};
            tx_ready <= slow ? pat[0] : 1'b1;
        end
    end

    // log accepted frames in arrival order, with cycle stamps
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rstn && tx_valid && tx_ready) begin
            got.push_back(tx_frame);
            stamp.push_back(cyc);
        end
    end

    // one-cycle receive strobe, then scramble the idle lines
    task automatic send(input logic [10:0] id, input logic rtr,
                        input logic [3:0] dlc, input logic [63:0] data);
        can_frame_t f;
        f = '{id: id, rtr: rtr, dlc: dlc, data: data};
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_frame <= f;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
    endtask
endmodule

// >>> sim/encnode_top_tb.sv
// self-checking bench for the encoder node states and position sends
`timescale 1ns/1ps
module encnode_top_tb
    import encnode_pkg::*;
;
    localparam int MSC = 20;
    localparam int LIMIT = 20000;
    logic clk, rstn, psel, penable, pwrite, slow, pready, pslverr, er;
    logic rx_valid, tx_valid, tx_ready, sdo_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, pre, rnd;
    can_frame_t rx_frame, tx_frame;
    logic [1:0] pos_toggle, pos_stale;
    logic [1:0][31:0] pos_raw;
    node_state_t node_state;
    int n_mismatch, cmp_count, cyc;
    logic [7:0] cd [8] = '{CMD_START, CMD_START, CMD_STOP, CMD_PREOP,
        CMD_STOP, CMD_START, CMD_PREOP, CMD_START};
    logic [7:0] tg [8] = '{8'h05, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00,
        8'h00, 8'h01};
    node_state_t ex [8] = '{ST_PREOP, ST_OPER, ST_STOP, ST_PREOP, ST_STOP,
        ST_OPER, ST_PREOP, ST_OPER};

    encnode_top #(.MS_CYCLES(MSC)) uut (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid),
        .tx_frame(tx_frame), .tx_ready(tx_ready), .pos_toggle(pos_toggle),
        .pos_raw(pos_raw), .node_state(node_state), .sdo_enable(sdo_enable),
        .pos_stale(pos_stale));
    can_master_model m (.clk(clk), .rstn(rstn), .slow(slow),
        .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_frame(rx_frame));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    function automatic can_frame_t pdo(input int ch);
        can_frame_t f;
        f.id = 11'(ID_PDO_BASE + ID_PDO_STEP * ch + 1);
        f.rtr = 1'b0;
        f.dlc = DLC_PDO;
        f.data = {32'h00000000, pos_raw[ch] + pre};
        return f;
    endfunction
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one APB transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        check(rd, e);
    endtask
    task automatic nmt(input logic [7:0] c, input logic [7:0] t);
        m.send(ID_NMT, 1'b0, DLC_NMT, {48'h0, t, c});
        @(posedge clk);
    endtask
    task automatic sync();
        m.send(ID_SYNC, 1'b0, 4'h0, 64'h0);
    endtask
    task automatic wait_n(input int n, input int lim);
        for (int i = 0; i < lim && m.got.size() < n; i++) @(posedge clk);
    endtask
    task automatic new_pos();
        pos_raw[0] <= xs();
        pos_raw[1] <= xs();
        repeat (6) @(posedge clk);
        pos_toggle <= ~pos_toggle;
        repeat (10) @(posedge clk);
    endtask
    task automatic chk_pdo(input int ch);
        can_frame_t s;
        can_frame_t e;
        s = '0;
        e = pdo(ch);
        foreach (m.got[i]) if (m.got[i].id == e.id) s = m.got[i];
        check(s, e);
    endtask

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rnd = 32'h169B9DB5;
        {rstn, psel, penable, pwrite, slow} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pos_toggle = 2'h0;
        pos_raw = '0;
        pre = 32'h00000000;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 100 && node_state !== ST_PREOP; i++)
            @(posedge clk);
        check(m.got[0], {ID_BOOT + 11'h001, 1'b0, DLC_BOOT, 64'h0});
        check(node_state, ST_PREOP);
        rchk(ADDR_CTRL, 32'h00000201);
        rchk(ADDR_CYCLE, 32'h00000063);
        rchk(ADDR_SYNC, 32'h00000001);
        rchk(ADDR_PRESET, 32'h00000000);
        rchk(8'h40, 32'h00000000);
        check(er, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        check(er, 1'b0);
        pre = xs();
        apb(1'b1, ADDR_PRESET, pre);
        new_pos();
        m.got.delete();
        sync();
        repeat (20) @(posedge clk);
        check(m.got.size(), 0);
        for (int i = 0; i < 8; i++) begin
            nmt(cd[i], tg[i]);
            check(node_state, ex[i]);
            check(sdo_enable, ex[i] != ST_STOP);
        end
        // sync replies from both channels through a stalling controller
        slow <= 1'b1;
        new_pos();
        m.got.delete();
        sync();
        wait_n(2, MSC * 10);
        chk_pdo(0);
        chk_pdo(1);
        slow <= 1'b0;
        apb(1'b1, ADDR_SYNC, 32'h00000003);
        m.got.delete();
        sync();
        sync();
        repeat (20) @(posedge clk);
        check(m.got.size(), 0);
        sync();
        wait_n(2, 40);
        check(m.got.size(), 2);
        // remote request answered for the matching channel only
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        new_pos();
        m.got.delete();
        m.send(11'(ID_PDO_BASE + ID_PDO_STEP + 1), 1'b1, 4'h0, 64'h0);
        repeat (20) @(posedge clk);
        check(m.got.size(), 1);
        chk_pdo(1);
        apb(1'b1, ADDR_CYCLE, 32'h00000002);
        apb(1'b1, ADDR_CTRL, 32'h00000101);
        m.got.delete();
        m.stamp.delete();
        wait_n(3, 400);
        check(m.stamp[2] - m.stamp[0], 3 * MSC);
        nmt(CMD_STOP, NODE_ALL);
        repeat (3) @(posedge clk);
        m.got.delete();
        repeat (150) @(posedge clk);
        check(m.got.size(), 0);
        // both resets rejoin in pre-operational with a fresh bootup
        for (int i = 0; i < 2; i++) begin
            m.got.delete();
            nmt(i == 0 ? CMD_RST_COMM : CMD_RST_NODE, 8'(i));
            for (int k = 0; k < 100 && node_state !== ST_PREOP; k++)
                @(posedge clk);
            check(m.got[0].id, ID_BOOT + 11'h001);
            rchk(i == 0 ? ADDR_CTRL : ADDR_PRESET,
                 i == 0 ? 32'h00000201 : 32'h00000000);
        end
        new_pos();
        rchk(ADDR_POS_BASE + ADDR_STEP, pos_raw[1]);
        check(pos_stale, 2'h0);
        repeat (MEAS_CYCLES + 100) @(posedge clk);
        check(pos_stale, 2'h3);
        rchk(ADDR_STATUS, 32'h00000301);
        print_verdict();
    end
endmodule
